// file: src/dot_pkg.sv
package dot_pkg;

  // ==========================================================
  // Clock and timing figures.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REF_TO_PD_CYC = 1;
  localparam int MODESET_TO_PD_CYC = 12;
  localparam int MODESET_GAP_CYC = 4;
  localparam int TERM_HIGH_MIN_SHORT = 4;
  localparam int TERM_HIGH_MIN_BURST8 = 6;
  localparam int ASYNC_TERM_DELAY_MIN_PS = 2000;
  localparam int ASYNC_TERM_DELAY_MAX_PS = 8500;
  // A least time rounds up, never below one cycle.
  localparam int ASYNC_TERM_DELAY_CYC =
    (ASYNC_TERM_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_TERM_DELAY_MAX_CYC =
    ASYNC_TERM_DELAY_MAX_PS / CLK_PERIOD_PS;
  // Turn-off and dynamic change windows in tenths of a clock period.
  localparam int TERM_EDGE_MIN_X10 = 3;
  localparam int TERM_EDGE_MAX_X10 = 7;
  localparam int TERM_EDGE_EXTRA_CYC = TERM_EDGE_MAX_X10 / 10;
  localparam int WRLVL_FIRST_STROBE_CYC = 40;
  localparam int WRLVL_STROBE_ENABLE_CYC = 25;
  localparam int WRLVL_STROBE_HALF_CYC = 4;

  // ==========================================================
  // Command bus layout.
  localparam int ADDR_W = 16;
  localparam int LAT_W = 5;
  localparam int CNT_W = 6;
  localparam int PIPE_DEPTH = 32;
  localparam int MR_CWL_LSB = 0;
  localparam int MR_AL_LSB = 4;
  localparam int MR_FIELD_W = 4;
  localparam int MR_WRLVL_BIT = 8;
  localparam logic [3:0] RST_WRITE_CAS_LATENCY = 4'h5;
  localparam logic [3:0] RST_ADDITIVE_LATENCY = 4'h0;

  // ==========================================================
  // Controller register port.
  localparam int REG_AW = 4;
  localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] REG_CMD = 4'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h8;
  localparam int CTRL_PD_REQ = 0;
  localparam int CTRL_ODT_REQ = 1;
  localparam int CTRL_WL_RUN = 2;
  localparam int CMD_CODE_LSB = 16;
  localparam int CMD_BC4_BIT = 18;
  localparam logic [2:0] RST_CTRL = 3'h0;

  typedef enum logic [1:0] {CMD_NOP, CMD_REF, CMD_MRS, CMD_WR} dot_cmd_t;
  typedef enum logic [1:0] {TERM_OFF, TERM_NOM, TERM_WR} dot_term_t;

  // Turn-on and turn-off latency in clocks, floored at zero.
  function automatic logic [LAT_W-1:0] dot_term_latency(
    input logic [3:0] write_cas_latency,
    input logic [3:0] al
  );
    logic [LAT_W-1:0] sum;
    sum = {1'b0, write_cas_latency} + {1'b0, al};
    dot_term_latency = (sum > 5'h2) ? sum - 5'h2 : 5'h0;
  endfunction : dot_term_latency

endpackage : dot_pkg

// file: src/dot_link_if.sv
interface dot_link_if;
  import dot_pkg::*;

  // ==========================================================
  // Signals driven by the controller.
  dot_cmd_t cmd;
  logic [ADDR_W-1:0] addr;
  logic bc4;
  logic cke;
  logic odt;
  logic dqs;
  logic dqs_oe;
  // ==========================================================
  // Signals driven by the device.
  logic dq;
  logic dq_oe;
  // Resolved wire levels; an undriven line reads low here.
  logic dqs_line;
  logic dq_line;
  assign dqs_line = dqs_oe & dqs;
  assign dq_line = dq_oe & dq;

  modport ctrl (output cmd, addr, bc4, cke, odt, dqs, dqs_oe,
                input dq_line);
  modport dev (input cmd, addr, bc4, cke, odt, dqs_line,
               output dq, dq_oe);
endinterface : dot_link_if

// file: src/dot_dev.sv
module dot_dev
  import dot_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Link.
  dot_link_if.dev link,
  // User side.
  input wire logic i_ck_level,
  output dot_pkg::dot_term_t o_term_state,
  output logic o_in_wrlevel,
  output logic o_powerdown
);
  import dot_pkg::*;

  logic [3:0] cwl_reg, cwl_next, al_reg, al_next;
  logic wl_reg, wl_next;
  logic [PIPE_DEPTH-1:0] odt_pipe_reg, odt_pipe_next;
  logic [PIPE_DEPTH-1:0] wr_pipe_reg, wr_pipe_next;
  logic [PIPE_DEPTH-1:0] bl8_pipe_reg, bl8_pipe_next;
  logic [CNT_W-1:0] wr_win_reg, wr_win_next;
  dot_term_t term_reg, term_next;
  logic dqs_prev_reg, dq_reg, dq_next;
  logic ck_meta_reg, ck_sync_reg;
  logic [LAT_W-1:0] lat;
  logic odt_ref, wr_ref, bl8_ref, is_wr;

  // ==========================================================
  // Pin synchroniser for the sampled clock level.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ck_meta_reg <= 1'b0;
      ck_sync_reg <= 1'b0;
    end
    else
    begin
      ck_meta_reg <= i_ck_level;
      ck_sync_reg <= ck_meta_reg;
    end
  end

  // ==========================================================
  // Termination and leveling next state.
  always_comb
  begin
    cwl_next = cwl_reg;
    al_next = al_reg;
    wl_next = wl_reg;
    is_wr = (link.cmd == CMD_WR);
    if (link.cke && link.cmd == CMD_MRS)
    begin
      cwl_next = link.addr[MR_CWL_LSB +: MR_FIELD_W];
      al_next = link.addr[MR_AL_LSB +: MR_FIELD_W];
      wl_next = link.addr[MR_WRLVL_BIT];
    end
    lat = dot_term_latency(cwl_reg, al_reg);
    // Each clock is counted as one stage, whatever its period.
    odt_pipe_next = {odt_pipe_reg[PIPE_DEPTH-2:0], link.odt};
    wr_pipe_next = {wr_pipe_reg[PIPE_DEPTH-2:0], is_wr};
    bl8_pipe_next = {bl8_pipe_reg[PIPE_DEPTH-2:0], is_wr & ~link.bc4};
    if (lat == 5'h0)
    begin
      odt_ref = link.odt;
      wr_ref = is_wr;
      bl8_ref = is_wr & ~link.bc4;
    end
    else
    begin
      odt_ref = odt_pipe_reg[lat - 5'h1];
      wr_ref = wr_pipe_reg[lat - 5'h1];
      bl8_ref = bl8_pipe_reg[lat - 5'h1];
    end
    // The write window is the write's own part of the high time.
    if (wr_ref)
      wr_win_next = bl8_ref ? CNT_W'(TERM_HIGH_MIN_BURST8 - 1)
                            : CNT_W'(TERM_HIGH_MIN_SHORT - 1);
    else if (wr_win_reg != '0)
      wr_win_next = wr_win_reg - 6'h1;
    else
      wr_win_next = '0;
    if (!link.cke)
      // Power-down with DLL frozen: follow the pin after one clock.
      term_next = link.odt ? TERM_NOM : TERM_OFF;
    else if (odt_ref && (wr_ref || wr_win_reg != '0))
      term_next = TERM_WR;
    else if (odt_ref)
      term_next = TERM_NOM;
    else
      term_next = TERM_OFF;
    // Leveling: each strobe rise captures the clock level.
    dq_next = dq_reg;
    if (wl_reg && link.dqs_line && !dqs_prev_reg)
      dq_next = ck_sync_reg;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cwl_reg <= RST_WRITE_CAS_LATENCY;
      al_reg <= RST_ADDITIVE_LATENCY;
      wl_reg <= 1'b0;
      odt_pipe_reg <= '0;
      wr_pipe_reg <= '0;
      bl8_pipe_reg <= '0;
      wr_win_reg <= '0;
      term_reg <= TERM_OFF;
      dqs_prev_reg <= 1'b0;
      dq_reg <= 1'b0;
    end
    else
    begin
      cwl_reg <= cwl_next;
      al_reg <= al_next;
      wl_reg <= wl_next;
      odt_pipe_reg <= odt_pipe_next;
      wr_pipe_reg <= wr_pipe_next;
      bl8_pipe_reg <= bl8_pipe_next;
      wr_win_reg <= wr_win_next;
      term_reg <= term_next;
      dqs_prev_reg <= link.dqs_line;
      dq_reg <= dq_next;
    end
  end

  assign o_term_state = term_reg;
  assign o_in_wrlevel = wl_reg;
  assign o_powerdown = ~link.cke;
  assign link.dq = dq_reg;
  assign link.dq_oe = wl_reg;

endmodule : dot_dev

// file: src/dot_ctrl.sv
// Implementation choices: the placing of the registers and strobed register access.
module dot_ctrl
  import dot_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port.
  input wire logic [dot_pkg::REG_AW-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Link.
  dot_link_if.ctrl link
);
  import dot_pkg::*;

  typedef enum logic [1:0] {WL_OFF, WL_WAIT, WL_RUN} dot_wl_t;

  logic [2:0] ctrl_reg, ctrl_next;
  logic pend_reg, pend_next;
  dot_cmd_t pend_cmd_reg, pend_cmd_next;
  logic [ADDR_W-1:0] pend_addr_reg, pend_addr_next;
  logic pend_bc4_reg, pend_bc4_next;
  dot_cmd_t cmd_reg, cmd_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic bc4_reg, bc4_next;
  logic cke_reg, cke_next;
  logic odt_reg, odt_next;
  logic odt_bl8_reg, odt_bl8_next;
  logic [CNT_W-1:0] ref_cnt_reg, ref_cnt_next;
  logic [CNT_W-1:0] mrs_cnt_reg, mrs_cnt_next;
  logic [CNT_W-1:0] odt_cnt_reg, odt_cnt_next;
  logic [CNT_W-1:0] wl_cnt_reg, wl_cnt_next;
  logic [CNT_W-1:0] odt_min;
  dot_wl_t wl_reg, wl_next;
  logic dqs_reg, dqs_next;
  logic dqs_oe_reg, dqs_oe_next;
  logic sample_reg, sample_next;
  logic [31:0] rdata_reg, rdata_next;
  logic issue, mrs_ok, pd_ok, odt_drop_ok;

  function automatic logic [CNT_W-1:0] dot_sat_inc(
    input logic [CNT_W-1:0] v
  );
    dot_sat_inc = (v == '1) ? v : v + 6'h1;
  endfunction : dot_sat_inc

  // ==========================================================
  // Command scheduling and pin timing.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    pend_next = pend_reg;
    pend_cmd_next = pend_cmd_reg;
    pend_addr_next = pend_addr_reg;
    pend_bc4_next = pend_bc4_reg;
    if (i_wr && i_addr == REG_CTRL)
      ctrl_next = i_wdata[2:0];
    // A command written while one is pending is ignored.
    if (i_wr && i_addr == REG_CMD && !pend_reg)
    begin
      pend_next = 1'b1;
      pend_cmd_next = dot_cmd_t'(i_wdata[CMD_CODE_LSB +: 2]);
      pend_addr_next = i_wdata[ADDR_W-1:0];
      pend_bc4_next = i_wdata[CMD_BC4_BIT];
    end
    // Counters advance once per clock edge, never by elapsed time.
    ref_cnt_next = dot_sat_inc(ref_cnt_reg);
    mrs_cnt_next = dot_sat_inc(mrs_cnt_reg);
    odt_cnt_next = dot_sat_inc(odt_cnt_reg);
    mrs_ok = (mrs_cnt_reg >= CNT_W'(MODESET_GAP_CYC));
    issue = pend_reg && cke_reg && cke_next_hold()
            && (pend_cmd_reg != CMD_MRS || mrs_ok);
    cmd_next = CMD_NOP;
    addr_next = addr_reg;
    bc4_next = bc4_reg;
    odt_bl8_next = odt_bl8_reg;
    if (issue)
    begin
      pend_next = 1'b0;
      cmd_next = pend_cmd_reg;
      addr_next = pend_addr_reg;
      bc4_next = pend_bc4_reg;
      if (pend_cmd_reg == CMD_REF)
        ref_cnt_next = 6'h1;
      if (pend_cmd_reg == CMD_MRS)
        mrs_cnt_next = 6'h1;
      if (pend_cmd_reg == CMD_WR && odt_reg)
      begin
        odt_cnt_next = 6'h1;
        odt_bl8_next = ~pend_bc4_reg;
      end
    end
    pd_ok = (ref_cnt_reg >= CNT_W'(REF_TO_PD_CYC))
            && (mrs_cnt_reg >= CNT_W'(MODESET_TO_PD_CYC));
    cke_next = cke_reg;
    if (ctrl_reg[CTRL_PD_REQ] && !pend_reg && pd_ok && cmd_reg == CMD_NOP)
      cke_next = 1'b0;
    else if (!ctrl_reg[CTRL_PD_REQ])
      cke_next = 1'b1;
    odt_min = odt_bl8_reg ? CNT_W'(TERM_HIGH_MIN_BURST8)
                          : CNT_W'(TERM_HIGH_MIN_SHORT);
    odt_drop_ok = (odt_cnt_reg >= odt_min);
    odt_next = odt_reg;
    if (ctrl_reg[CTRL_ODT_REQ] && !odt_reg)
    begin
      odt_next = 1'b1;
      odt_cnt_next = 6'h1;
      odt_bl8_next = 1'b0;
    end
    else if (!ctrl_reg[CTRL_ODT_REQ] && odt_reg && odt_drop_ok)
      odt_next = 1'b0;
  end

  // The next value of CKE must stay high in the cycle a command goes.
  function automatic logic cke_next_hold();
    cke_next_hold = !ctrl_reg[CTRL_PD_REQ] || !pd_ok_now();
  endfunction : cke_next_hold

  function automatic logic pd_ok_now();
    pd_ok_now = (ref_cnt_reg >= CNT_W'(REF_TO_PD_CYC))
                && (mrs_cnt_reg >= CNT_W'(MODESET_TO_PD_CYC));
  endfunction : pd_ok_now

  // ==========================================================
  // Write leveling strobe sequence.
  always_comb
  begin
    wl_next = wl_reg;
    wl_cnt_next = dot_sat_inc(wl_cnt_reg);
    dqs_next = 1'b0;
    dqs_oe_next = 1'b0;
    sample_next = sample_reg;
    if (cmd_reg == CMD_MRS)
    begin
      wl_next = addr_reg[MR_WRLVL_BIT] ? WL_WAIT : WL_OFF;
      wl_cnt_next = 6'h1;
    end
    else
    begin
      case (wl_reg)
        WL_OFF:
          wl_cnt_next = '0;
        WL_WAIT:
        begin
          dqs_oe_next = (wl_cnt_reg >= CNT_W'(WRLVL_STROBE_ENABLE_CYC));
          if (wl_cnt_reg >= CNT_W'(WRLVL_FIRST_STROBE_CYC)
              && ctrl_reg[CTRL_WL_RUN])
          begin
            wl_next = WL_RUN;
            wl_cnt_next = '0;
          end
        end
        WL_RUN:
        begin
          dqs_oe_next = 1'b1;
          // The phase counter wraps here; saturating would freeze the
          // strobe high after a long leveling run.
          wl_cnt_next = wl_cnt_reg + 6'h1;
          // Slow strobe: rises every two half periods, low before.
          dqs_next = (wl_cnt_reg[2:0] >= 3'(WRLVL_STROBE_HALF_CYC));
          if (!ctrl_reg[CTRL_WL_RUN])
            wl_next = WL_WAIT;
        end
        default:
          wl_next = WL_OFF;
      endcase
    end
    if (wl_reg != WL_OFF)
      sample_next = link.dq_line;
  end

  // ==========================================================
  // Register read port, one cycle latency.
  always_comb
  begin
    rdata_next = '0;
    if (i_rd)
    begin
      case (i_addr)
        REG_CTRL:
          rdata_next = {29'h0, ctrl_reg};
        REG_CMD:
          rdata_next = {13'h0, pend_bc4_reg, pend_cmd_reg, pend_addr_reg};
        REG_STATUS:
          rdata_next = {26'h0, dqs_oe_reg, sample_reg, wl_reg != WL_OFF,
                        odt_reg, cke_reg, pend_reg};
        default:
          rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl_reg <= RST_CTRL;
      pend_reg <= 1'b0;
      pend_cmd_reg <= CMD_NOP;
      pend_addr_reg <= '0;
      pend_bc4_reg <= 1'b0;
      cmd_reg <= CMD_NOP;
      addr_reg <= '0;
      bc4_reg <= 1'b0;
      cke_reg <= 1'b1;
      odt_reg <= 1'b0;
      odt_bl8_reg <= 1'b0;
      ref_cnt_reg <= '1;
      mrs_cnt_reg <= '1;
      odt_cnt_reg <= '1;
      wl_cnt_reg <= '0;
      wl_reg <= WL_OFF;
      dqs_reg <= 1'b0;
      dqs_oe_reg <= 1'b0;
      sample_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      pend_reg <= pend_next;
      pend_cmd_reg <= pend_cmd_next;
      pend_addr_reg <= pend_addr_next;
      pend_bc4_reg <= pend_bc4_next;
      cmd_reg <= cmd_next;
      addr_reg <= addr_next;
      bc4_reg <= bc4_next;
      cke_reg <= cke_next;
      odt_reg <= odt_next;
      odt_bl8_reg <= odt_bl8_next;
      ref_cnt_reg <= ref_cnt_next;
      mrs_cnt_reg <= mrs_cnt_next;
      odt_cnt_reg <= odt_cnt_next;
      wl_cnt_reg <= wl_cnt_next;
      wl_reg <= wl_next;
      dqs_reg <= dqs_next;
      dqs_oe_reg <= dqs_oe_next;
      sample_reg <= sample_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign link.cmd = cmd_reg;
  assign link.addr = addr_reg;
  assign link.bc4 = bc4_reg;
  assign link.cke = cke_reg;
  assign link.odt = odt_reg;
  assign link.dqs = dqs_reg;
  assign link.dqs_oe = dqs_oe_reg;

endmodule : dot_ctrl

// file: verif/dot_link_checker.sv
module dot_link_checker
  import dot_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Link signals.
  input wire dot_pkg::dot_cmd_t cmd,
  input wire logic [dot_pkg::ADDR_W-1:0] addr,
  input wire logic bc4,
  input wire logic cke,
  input wire logic odt,
  input wire logic dqs_oe,
  input wire logic dqs_line,
  input wire logic dq_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // ==========================================================
  // Edge counters since the last mode-set commands.
  // They saturate, so a long idle run never wraps into a false age.
  logic [6:0] mrs_age_reg;
  logic [6:0] mrs_age_next;
  logic [6:0] wl_age_reg;
  logic [6:0] wl_age_next;

  always_comb
  begin
    mrs_age_next = mrs_age_reg;
    wl_age_next = wl_age_reg;
    if (mrs_age_reg != 7'h7f)
      mrs_age_next = mrs_age_reg + 7'h01;
    if (wl_age_reg != 7'h7f)
      wl_age_next = wl_age_reg + 7'h01;
    if (cmd == CMD_MRS)
    begin
      mrs_age_next = 7'h01;
      if (addr[MR_WRLVL_BIT])
        wl_age_next = 7'h01;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mrs_age_reg <= 7'h7f;
      wl_age_reg <= 7'h7f;
    end
    else
    begin
      mrs_age_reg <= mrs_age_next;
      wl_age_reg <= wl_age_next;
    end
  end

  // ==========================================================
  // Link timing.
  sequence s_wl_mrs;
    cmd == CMD_MRS && addr[MR_WRLVL_BIT] && cke;
  endsequence
  sequence s_odt_hold4;
    odt [*4];
  endsequence

  property p_ref_pd;
    cmd == CMD_REF |=> cke;
  endproperty
  a_ref_pd: assert property (p_ref_pd)
    else $error("power-down entered right after refresh");

  property p_mrs_pd;
    $fell(cke) |-> mrs_age_reg >= MODESET_TO_PD_CYC;
  endproperty
  a_mrs_pd: assert property (p_mrs_pd)
    else $error("power-down entered too soon after mode set");

  property p_odt_short;
    $rose(odt) |-> s_odt_hold4;
  endproperty
  a_odt_short: assert property (p_odt_short)
    else $error("termination request high too briefly");

  property p_odt_bl8;
    cmd == CMD_WR && !bc4 && odt |-> odt [*6];
  endproperty
  a_odt_bl8: assert property (p_odt_bl8)
    else $error("termination request dropped during long write");

  property p_wl_first;
    $rose(dqs_line) |-> wl_age_reg >= WRLVL_FIRST_STROBE_CYC;
  endproperty
  a_wl_first: assert property (p_wl_first)
    else $error("first leveling strobe too early");

  property p_wl_enable;
    $rose(dqs_oe) |-> wl_age_reg >= WRLVL_STROBE_ENABLE_CYC;
  endproperty
  a_wl_enable: assert property (p_wl_enable)
    else $error("strobe drivers enabled too early");

  property p_mrs_gap;
    cmd == CMD_MRS |=> (cmd != CMD_MRS) [*3];
  endproperty
  a_mrs_gap: assert property (p_mrs_gap)
    else $error("mode-set commands too close");

  property p_wl_feedback;
    s_wl_mrs |=> dq_oe;
  endproperty
  a_wl_feedback: assert property (p_wl_feedback)
    else $error("leveling feedback not driven");

endmodule : dot_link_checker

// file: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dot_pkg::*;

  logic i_clk;
  logic i_arst_n;
  logic [REG_AW-1:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic i_ck_level;
  dot_term_t o_term_state;
  logic o_in_wrlevel;
  logic o_powerdown;
  int n_errors;
  int n_checks;
  int cyc = 0;

  dot_link_if dot_link_if_i ();
  dot_ctrl dot_ctrl_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .link(dot_link_if_i));
  dot_dev dot_dev_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .link(dot_link_if_i), .i_ck_level(i_ck_level),
    .o_term_state(o_term_state), .o_in_wrlevel(o_in_wrlevel),
    .o_powerdown(o_powerdown));
  dot_link_checker dot_link_checker_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .cmd(dot_link_if_i.cmd), .addr(dot_link_if_i.addr),
    .bc4(dot_link_if_i.bc4), .cke(dot_link_if_i.cke),
    .odt(dot_link_if_i.odt), .dqs_oe(dot_link_if_i.dqs_oe),
    .dqs_line(dot_link_if_i.dqs_line), .dq_oe(dot_link_if_i.dq_oe));

  initial i_clk = 1'b0;
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;

  // ==========================================================
  // Checking and closing.
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h", $time, what, got);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic timeout(input string what);
    n_errors++;
    $display("wrong value at %0t: no %s", $time, what);
    final_report();
  endtask : timeout

  // ==========================================================
  // Bus tasks; each ends just after an edge so polling starts there.
  task automatic tk();
    @(posedge i_clk);
    #1;
  endtask : tk

  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [REG_AW-1:0] a, input logic [31:0] m,
                    input logic [31:0] exp, input string what);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata & m, exp, what);
  endtask : rd

  task automatic issue(input dot_cmd_t c, input logic [15:0] a,
                       input logic b, output int at);
    int i;
    wr(REG_CMD, (32'(b) << CMD_BC4_BIT) | (32'(c) << CMD_CODE_LSB) | 32'(a));
    for (i = 0; i < 40 && dot_link_if_i.cmd !== c; i++) tk();
    if (i == 40) timeout("command");
    at = cyc;
  endtask : issue

  // Counts edges from the pin change until the termination state.
  task automatic term_lat(input logic [31:0] cv, input dot_term_t et,
                          input logic lvl, input int exp_n);
    int i;
    int n;
    wr(REG_CTRL, cv);
    for (i = 0; i < 40 && dot_link_if_i.odt !== lvl; i++) tk();
    for (n = 0; n < 40 && o_term_state !== et; n++) tk();
    if (i == 40 || n == 40) timeout("termination");
    check(32'(n), 32'(exp_n), "termination latency");
  endtask : term_lat

  function automatic int model_lat(input int write_cas_latency, input int al);
    return ((write_cas_latency + al > 2) ? write_cas_latency + al - 2 : 0) + 1;
  endfunction : model_lat

  // ==========================================================
  // Main sequence.
  initial
  begin
    int write_cas_latency;
    int al;
    int i;
    int n;
    int k;
    int t0;
    int t1;
    logic lvl;
    i_arst_n = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_ck_level = 1'b0;
    n_errors = 0;
    n_checks = 0;
    void'($urandom(32'hd03b));
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    tk();
    rd(REG_STATUS, 32'hffffffff, 32'h2, "status reset");
    rd(REG_CTRL, 32'hffffffff, 32'h0, "control reset");
    rd(4'hc, 32'hffffffff, 32'h0, "unmapped read");
    $display("test reset done");
    for (k = 0; k < 3; k++)
    begin
      write_cas_latency = 5 + $urandom % 5;
      al = $urandom % 3;
      issue(CMD_MRS, 16'((al << MR_AL_LSB) | write_cas_latency), 1'b0, t0);
      issue(CMD_MRS, 16'((al << MR_AL_LSB) | write_cas_latency), 1'b0, t1);
      check(32'(t1 - t0 >= MODESET_GAP_CYC), 32'h1, "mode-set gap");
      term_lat(32'h2, TERM_NOM, 1'b1, model_lat(write_cas_latency, al));
      term_lat(32'h0, TERM_OFF, 1'b0, model_lat(write_cas_latency, al));
    end
    $display("test latency done");
    term_lat(32'h2, TERM_NOM, 1'b1, model_lat(write_cas_latency, al));
    for (k = 0; k < 2; k++)
    begin
      issue(CMD_WR, 16'h0, k[0], t0);
      for (i = 0; i < 40 && o_term_state !== TERM_WR; i++) tk();
      for (n = 0; n < 40 && o_term_state === TERM_WR; n++) tk();
      if (i == 40 || n == 40) timeout("write termination");
      check(32'(n), 32'(k ? TERM_HIGH_MIN_SHORT : TERM_HIGH_MIN_BURST8),
            "write termination length");
      check(32'(o_term_state), 32'(TERM_NOM), "back to nominal");
    end
    term_lat(32'h0, TERM_OFF, 1'b0, model_lat(write_cas_latency, al));
    $display("test dynamic done");
    issue(CMD_MRS, 16'((al << MR_AL_LSB) | write_cas_latency), 1'b0, t0);
    issue(CMD_REF, 16'h0, 1'b0, t1);
    wr(REG_CTRL, 32'h1);
    for (i = 0; i < 60 && dot_link_if_i.cke !== 1'b0; i++) tk();
    if (i == 60) timeout("power-down");
    check(32'(cyc - t0 >= MODESET_TO_PD_CYC), 32'h1, "pd after mrs");
    check(32'(o_powerdown), 32'h1, "power-down flag");
    term_lat(32'h3, TERM_NOM, 1'b1, ASYNC_TERM_DELAY_CYC);
    term_lat(32'h1, TERM_OFF, 1'b0, ASYNC_TERM_DELAY_CYC);
    wr(REG_CTRL, 32'h0);
    for (i = 0; i < 60 && dot_link_if_i.cke !== 1'b1; i++) tk();
    if (i == 60) timeout("power-up");
    $display("test power-down done");
    issue(CMD_MRS, 16'h100 | 16'((al << MR_AL_LSB) | write_cas_latency), 1'b0, t0);
    wr(REG_CTRL, 32'h4);
    for (i = 0; i < 200 && dot_link_if_i.dqs_line !== 1'b1; i++) tk();
    if (i == 200) timeout("leveling strobe");
    check(32'(cyc - t0 >= WRLVL_FIRST_STROBE_CYC), 32'h1, "first rise");
    check(32'(o_in_wrlevel), 32'h1, "leveling flag");
    lvl = 1'($urandom % 2);
    for (k = 0; k < 2; k++)
    begin
      @(posedge i_clk);
      i_ck_level <= lvl ^ k[0];
      repeat (24) tk();
      rd(REG_STATUS, 32'h30, {26'h0, 1'b1, lvl ^ k[0], 4'h0},
         "sampled level");
    end
    $display("test leveling done");
    final_report();
  end

endmodule : tb_top
